//--- logic/capture_compare_timer_regs.sv
// capture/compare timer: 16-bit counter, two captures, two compares,
// one-pulse and pulse-width modes, registers over axi4-lite.
// assumes pins and bus are synchronous to i_clk_sys.
`timescale 1ns/1ns
module capture_compare_timer_regs #(
  parameter bit EXT_CLK_PRESENT = 1'b1
) (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  // axi4-lite write address and data
  input  wire logic [31:0] i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  // axi4-lite write response
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  // axi4-lite read
  input  wire logic [31:0] i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // timer pins
  input  wire logic        i_capture_pin_one,
  input  wire logic        i_capture_pin_two,
  input  wire logic        i_ext_clock_pin,
  output logic             o_compare_pin_one,
  output logic             o_compare_pin_one_en,
  output logic             o_compare_pin_two,
  output logic             o_compare_pin_two_en,
  // timer interrupt request
  output logic             o_timer_irq
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  // returns {hit, index}; anything off the aligned map misses
  function automatic logic [4:0] reg_decode(input logic [31:0] addr);
    logic hit;
    hit = (addr[31:6] == 26'h0) && (addr[1:0] == 2'h0)
          && (addr[5:2] <= capture_compare_timer_pkg::IDX_LAST);
    return {hit, addr[5:2]};
  endfunction : reg_decode

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  capture_compare_timer_pkg::ctrl_one_s ctrl_one_r;
  capture_compare_timer_pkg::ctrl_two_s ctrl_two_r;
  logic [4:0]  flags_r;     // cap1 cmp1 ovf cap2 cmp2
  logic [4:0]  armed_r;     // flags seen by a status read
  logic [15:0] cnt_r;
  logic [15:0] cmp_one_r;
  logic [15:0] cmp_two_r;
  logic [15:0] cap_one_r;
  logic [15:0] cap_two_r;
  logic        inhib_one_r;
  logic        inhib_two_r;
  logic [2:0]  presc_r;
  logic        cap_one_q_r;
  logic        cap_two_q_r;
  logic        ext_q_r;
  logic        aw_full_r;
  logic        w_full_r;
  logic [31:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;

  // ---------------------------------------------------------------
  // bus handshakes
  // ---------------------------------------------------------------
  wire logic        aw_take   = i_awvalid & o_awready;
  wire logic        w_take    = i_wvalid & o_wready;
  wire logic        wr_fire   = aw_full_r & w_full_r & ~o_bvalid;
  wire logic [4:0]  wr_dec    = reg_decode(aw_addr_r);
  wire logic        wr_ok     = wr_fire & wr_dec[4] & w_strb_r[0];
  wire logic [7:0]  wd        = w_data_r[7:0];
  wire logic        rd_fire   = i_arvalid & o_arready;
  wire logic [4:0]  rd_dec    = reg_decode(i_araddr);
  wire logic        rd_ok     = rd_fire & rd_dec[4];
  wire logic        b_done    = o_bvalid & i_bready;
  wire logic        aw_full_nxt = (aw_full_r | aw_take) & ~wr_fire;
  wire logic        w_full_nxt  = (w_full_r | w_take) & ~wr_fire;
  wire logic        bvalid_nxt  = wr_fire | (o_bvalid & ~i_bready);
  wire logic        rvalid_nxt  = rd_fire | (o_rvalid & ~i_rready);

  // per-register write and access strobes (access = read or write)
  wire logic we_ctrl_one  = wr_ok & (wr_dec[3:0] == capture_compare_timer_pkg::IDX_CTRL_ONE);
  wire logic we_ctrl_two  = wr_ok & (wr_dec[3:0] == capture_compare_timer_pkg::IDX_CTRL_TWO);
  wire logic we_cmp1_hi   = wr_ok & (wr_dec[3:0] == capture_compare_timer_pkg::IDX_CMP_ONE_HI);
  wire logic we_cmp1_lo   = wr_ok & (wr_dec[3:0] == capture_compare_timer_pkg::IDX_CMP_ONE_LO);
  wire logic we_cmp2_hi   = wr_ok & (wr_dec[3:0] == capture_compare_timer_pkg::IDX_CMP_TWO_HI);
  wire logic we_cmp2_lo   = wr_ok & (wr_dec[3:0] == capture_compare_timer_pkg::IDX_CMP_TWO_LO);
  wire logic we_cnt_lo    = wr_ok & (wr_dec[3:0] == capture_compare_timer_pkg::IDX_CNT_LO);
  wire logic we_alt_lo    = wr_ok & (wr_dec[3:0] == capture_compare_timer_pkg::IDX_ALT_CNT_LO);
  wire logic rd_status    = rd_ok & (rd_dec[3:0] == capture_compare_timer_pkg::IDX_STATUS);
  wire logic acc_cap1_lo  = (rd_ok & (rd_dec[3:0] == capture_compare_timer_pkg::IDX_CAP_ONE_LO))
                          | (wr_ok & (wr_dec[3:0] == capture_compare_timer_pkg::IDX_CAP_ONE_LO));
  wire logic acc_cap2_lo  = (rd_ok & (rd_dec[3:0] == capture_compare_timer_pkg::IDX_CAP_TWO_LO))
                          | (wr_ok & (wr_dec[3:0] == capture_compare_timer_pkg::IDX_CAP_TWO_LO));
  wire logic acc_cmp1_lo  = (rd_ok & (rd_dec[3:0] == capture_compare_timer_pkg::IDX_CMP_ONE_LO))
                          | we_cmp1_lo;
  wire logic acc_cmp2_lo  = (rd_ok & (rd_dec[3:0] == capture_compare_timer_pkg::IDX_CMP_TWO_LO))
                          | we_cmp2_lo;
  // alternate counter low is left out on purpose: it never clears overflow
  wire logic acc_cnt_lo   = (rd_ok & (rd_dec[3:0] == capture_compare_timer_pkg::IDX_CNT_LO))
                          | we_cnt_lo;

  // ---------------------------------------------------------------
  // timer clock selection and edge detection
  // ---------------------------------------------------------------
  wire logic ext_edge  = ctrl_two_r.ext_clock_edge ? (i_ext_clock_pin & ~ext_q_r)
                                                   : (~i_ext_clock_pin & ext_q_r);
  wire logic cap1_edge = ctrl_one_r.capture_one_edge ? (i_capture_pin_one & ~cap_one_q_r)
                                                     : (~i_capture_pin_one & cap_one_q_r);
  wire logic cap2_edge = ctrl_two_r.capture_two_edge ? (i_capture_pin_two & ~cap_two_q_r)
                                                     : (~i_capture_pin_two & cap_two_q_r);
  wire logic [1:0] csel = ctrl_two_r.clock_select_field;
  // external setting with no pin gives no tick, so the count freezes
  wire logic tick =
      (csel == capture_compare_timer_pkg::CLK_DIV4) ? (presc_r[1:0] == 2'h3) :
      (csel == capture_compare_timer_pkg::CLK_DIV2) ? presc_r[0] :
      (csel == capture_compare_timer_pkg::CLK_DIV8) ? (presc_r == 3'h7) :
      (EXT_CLK_PRESENT & ext_edge);

  // ---------------------------------------------------------------
  // modes, matches and flag events
  // ---------------------------------------------------------------
  wire logic pwm_act   = ctrl_two_r.pulse_width_mode;
  wire logic os_act    = ctrl_two_r.one_pulse_mode & ~ctrl_two_r.pulse_width_mode;
  wire logic os_trig   = os_act & cap1_edge;
  // compare keeps running whatever the pin enables say
  wire logic match_one = tick & ~inhib_one_r & (cnt_r == cmp_one_r);
  wire logic match_two = tick & ~inhib_two_r & (cnt_r == cmp_two_r);
  wire logic cnt_reset = we_cnt_lo | we_alt_lo;
  wire logic wrap      = tick & (cnt_r == capture_compare_timer_pkg::CNT_TOP)
                         & ~(pwm_act & match_two);
  wire logic cap1_load = cap1_edge & ~pwm_act & ~os_act;
  wire logic [4:0] flag_set = {
      cap1_edge & ~pwm_act | pwm_act & match_two,
      match_one & ~pwm_act & ~os_act,
      wrap,
      cap2_edge,
      match_two & ~pwm_act
  };
  wire logic [4:0] flag_acc = {acc_cap1_lo, acc_cmp1_lo, acc_cnt_lo, acc_cap2_lo, acc_cmp2_lo};
  // a set in the clearing cycle survives the clear
  wire logic [4:0] flags_nxt = flag_set | (flags_r & ~(armed_r & flag_acc));
  wire logic [4:0] armed_nxt = rd_status ? flags_r : (armed_r & ~flag_acc);

  wire logic [15:0] cnt_nxt =
      cnt_reset                   ? capture_compare_timer_pkg::CNT_RELOAD :
      os_trig                     ? capture_compare_timer_pkg::CNT_RELOAD :
      (pwm_act & match_two)       ? capture_compare_timer_pkg::CNT_RELOAD :
      tick                        ? cnt_r + 16'h0001 : cnt_r;

  // ---------------------------------------------------------------
  // compare pins
  // ---------------------------------------------------------------
  wire logic force_one = we_ctrl_one & wd[3] & ctrl_two_r.compare_one_pin_enable;
  wire logic force_two = we_ctrl_one & wd[4] & ctrl_two_r.compare_two_pin_enable;
  wire logic pin_one_nxt =
      force_one ? wd[0] :
      ~ctrl_two_r.compare_one_pin_enable ? o_compare_pin_one :
      (pwm_act & match_two) ? ctrl_one_r.level_two :
      os_trig ? ctrl_one_r.level_two :
      match_one ? ctrl_one_r.level_one : o_compare_pin_one;
  wire logic pin_two_nxt =
      force_two ? wd[2] :
      (ctrl_two_r.compare_two_pin_enable & match_two & ~pwm_act & ~os_act)
        ? ctrl_one_r.level_two : o_compare_pin_two;
  wire logic irq_nxt =
      (ctrl_one_r.capture_irq_enable  & (flags_r[4] | flags_r[1])) |
      (ctrl_one_r.compare_irq_enable  & (flags_r[3] | flags_r[0])) |
      (ctrl_one_r.overflow_irq_enable & flags_r[2]);

  // ---------------------------------------------------------------
  // read bank
  // ---------------------------------------------------------------
  logic [7:0] rd_bank [0:15];
  assign rd_bank[0]  = ctrl_one_r;
  assign rd_bank[1]  = ctrl_two_r;
  assign rd_bank[2]  = {flags_r, 3'h0};
  assign rd_bank[3]  = cap_one_r[15:8];
  assign rd_bank[4]  = cap_one_r[7:0];
  assign rd_bank[5]  = cmp_one_r[15:8];
  assign rd_bank[6]  = cmp_one_r[7:0];
  assign rd_bank[7]  = cmp_two_r[15:8];
  assign rd_bank[8]  = cmp_two_r[7:0];
  assign rd_bank[9]  = cnt_r[15:8];
  assign rd_bank[10] = cnt_r[7:0];
  assign rd_bank[11] = cnt_r[15:8];
  assign rd_bank[12] = cnt_r[7:0];
  assign rd_bank[13] = cap_two_r[15:8];
  assign rd_bank[14] = cap_two_r[7:0];
  assign rd_bank[15] = 8'h00;

  // ---------------------------------------------------------------
  // bus registers
  // ---------------------------------------------------------------
  // ready outputs are registered, so a taken beat drops ready next cycle
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= capture_compare_timer_pkg::RESP_OKAY;
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rresp   <= capture_compare_timer_pkg::RESP_OKAY;
      o_rdata   <= 32'h00000000;
    end else begin
      aw_full_r <= aw_full_nxt;
      w_full_r  <= w_full_nxt;
      o_awready <= ~aw_full_nxt & ~bvalid_nxt;
      o_wready  <= ~w_full_nxt & ~bvalid_nxt;
      o_bvalid  <= bvalid_nxt;
      o_arready <= ~rvalid_nxt;
      o_rvalid  <= rvalid_nxt;
      if (wr_fire) begin
        o_bresp <= wr_dec[4] ? capture_compare_timer_pkg::RESP_OKAY
                             : capture_compare_timer_pkg::RESP_DECERR;
      end
      if (rd_fire) begin
        o_rresp <= rd_dec[4] ? capture_compare_timer_pkg::RESP_OKAY
                             : capture_compare_timer_pkg::RESP_DECERR;
        o_rdata <= rd_dec[4] ? {24'h000000, rd_bank[rd_dec[3:0]]} : 32'h00000000;
      end
    end
  end

  // captured beats hold address and data until the write fires
  always_ff @(posedge i_clk_sys) begin
    if (aw_take) aw_addr_r <= i_awaddr;
    if (w_take) begin
      w_data_r <= i_wdata;
      w_strb_r <= i_wstrb;
    end
  end

  // ---------------------------------------------------------------
  // control, compare and counter registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      ctrl_one_r  <= capture_compare_timer_pkg::RST_CTRL;
      ctrl_two_r  <= capture_compare_timer_pkg::RST_CTRL;
      cmp_one_r   <= {capture_compare_timer_pkg::RST_CMP_HI, capture_compare_timer_pkg::RST_CMP_LO};
      cmp_two_r   <= {capture_compare_timer_pkg::RST_CMP_HI, capture_compare_timer_pkg::RST_CMP_LO};
      inhib_one_r <= 1'b0;
      inhib_two_r <= 1'b0;
      cnt_r       <= capture_compare_timer_pkg::CNT_RELOAD;
      presc_r     <= 3'h0;
    end else begin
      if (we_ctrl_one) ctrl_one_r <= wd;
      if (we_ctrl_two) ctrl_two_r <= wd;
      if (we_cmp1_hi) cmp_one_r[15:8] <= wd;
      if (we_cmp1_lo) cmp_one_r[7:0]  <= wd;
      if (we_cmp2_hi) cmp_two_r[15:8] <= wd;
      if (we_cmp2_lo) cmp_two_r[7:0]  <= wd;
      inhib_one_r <= we_cmp1_hi | (inhib_one_r & ~we_cmp1_lo);
      inhib_two_r <= we_cmp2_hi | (inhib_two_r & ~we_cmp2_lo);
      cnt_r       <= cnt_nxt;
      presc_r     <= presc_r + 3'h1;
    end
  end

  // ---------------------------------------------------------------
  // flags, pins, interrupt and edge history
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      flags_r              <= 5'h00;
      armed_r              <= 5'h00;
      o_compare_pin_one    <= 1'b0;
      o_compare_pin_two    <= 1'b0;
      o_compare_pin_one_en <= 1'b0;
      o_compare_pin_two_en <= 1'b0;
      o_timer_irq          <= 1'b0;
      cap_one_q_r          <= 1'b0;
      cap_two_q_r          <= 1'b0;
      ext_q_r              <= 1'b0;
    end else begin
      flags_r              <= flags_nxt;
      armed_r              <= armed_nxt;
      o_compare_pin_one    <= pin_one_nxt;
      o_compare_pin_two    <= pin_two_nxt;
      o_compare_pin_one_en <= ctrl_two_r.compare_one_pin_enable;
      o_compare_pin_two_en <= ctrl_two_r.compare_two_pin_enable;
      o_timer_irq          <= irq_nxt;
      cap_one_q_r          <= i_capture_pin_one;
      cap_two_q_r          <= i_capture_pin_two;
      ext_q_r              <= i_ext_clock_pin;
    end
  end

  // capture values are undefined after reset, so they carry no reset
  always_ff @(posedge i_clk_sys) begin
    if (cap1_load) cap_one_r <= cnt_r;
    if (cap2_edge) cap_two_r <= cnt_r;
  end

endmodule : capture_compare_timer_regs

//--- logic/capture_compare_timer_pkg.sv
// Contract
// - capture flags interrupt when capture enable set
// - compare flags interrupt when compare enable set
// - overflow flag interrupts when overflow enable set
// - force bit two drives level two
// - force bit one drives level one
// - compare two match drives level two
// - capture one edge bit picks edge
// - compare one match drives level one
// - pin enables gate pins, not compare logic
// - one pulse mode: capture edge starts pulse
// - pulse width mode: repeating waveform on pin
// - clock field picks divide or external clock
// - missing external pin halts the counter
// - capture two edge bit picks edge
// - external clock edge bit picks edge
// - capture one flag set and two-step clear
// - compare one flag set and two-step clear
// - overflow flag on wrap, counter low clears
// - capture two flag set and two-step clear
// - compare two flag set and two-step clear
// - low three status bits read zero
// - capture one event copies counter value
// - both modes set: pulse width wins
// - pulse width period reloads counter FFFCh
// - high byte write inhibits compare until low
//
// constants, register map and field layouts of the capture/compare timer.
// assumes a 32-bit axi4-lite master and one system clock.
package capture_compare_timer_pkg;

  // ---------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [3:0] IDX_CTRL_ONE    = 4'h0;
  localparam logic [3:0] IDX_CTRL_TWO    = 4'h1;
  localparam logic [3:0] IDX_STATUS      = 4'h2;
  localparam logic [3:0] IDX_CAP_ONE_HI  = 4'h3;
  localparam logic [3:0] IDX_CAP_ONE_LO  = 4'h4;
  localparam logic [3:0] IDX_CMP_ONE_HI  = 4'h5;
  localparam logic [3:0] IDX_CMP_ONE_LO  = 4'h6;
  localparam logic [3:0] IDX_CMP_TWO_HI  = 4'h7;
  localparam logic [3:0] IDX_CMP_TWO_LO  = 4'h8;
  localparam logic [3:0] IDX_CNT_HI      = 4'h9;
  localparam logic [3:0] IDX_CNT_LO      = 4'hA;
  localparam logic [3:0] IDX_ALT_CNT_HI  = 4'hB;
  localparam logic [3:0] IDX_ALT_CNT_LO  = 4'hC;
  localparam logic [3:0] IDX_CAP_TWO_HI  = 4'hD;
  localparam logic [3:0] IDX_CAP_TWO_LO  = 4'hE;
  localparam logic [3:0] IDX_LAST        = 4'hE;

  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [7:0]  RST_CTRL      = 8'h00;
  localparam logic [7:0]  RST_CMP_HI    = 8'h80;
  localparam logic [7:0]  RST_CMP_LO    = 8'h00;
  localparam logic [15:0] CNT_RELOAD    = 16'hFFFC;
  localparam logic [15:0] CNT_TOP       = 16'hFFFF;
  localparam logic [1:0]  CLK_DIV4      = 2'h0;
  localparam logic [1:0]  CLK_DIV2      = 2'h1;
  localparam logic [1:0]  CLK_DIV8      = 2'h2;
  localparam logic [1:0]  CLK_EXT       = 2'h3;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_DECERR   = 2'h3;

  // ---------------------------------------------------------------
  // status bit positions
  // ---------------------------------------------------------------
  localparam int ST_CAP1 = 7;
  localparam int ST_CMP1 = 6;
  localparam int ST_OVF  = 5;
  localparam int ST_CAP2 = 4;
  localparam int ST_CMP2 = 3;

  // control one layout, msb first
  typedef struct packed {
    logic capture_irq_enable;
    logic compare_irq_enable;
    logic overflow_irq_enable;
    logic force_compare_two;
    logic force_compare_one;
    logic level_two;
    logic capture_one_edge;
    logic level_one;
  } ctrl_one_s;

  // control two layout, msb first
  typedef struct packed {
    logic       compare_one_pin_enable;
    logic       compare_two_pin_enable;
    logic       one_pulse_mode;
    logic       pulse_width_mode;
    logic [1:0] clock_select_field;
    logic       capture_two_edge;
    logic       ext_clock_edge;
  } ctrl_two_s;

endpackage : capture_compare_timer_pkg

//--- verification/cct_far_side.sv
// far-side model: capture sources and the external count clock
// assumes the bench asks for pin levels through i_want
`timescale 1ns/1ns
module cct_far_side (
  // clock and requested levels: bit 0 capture one, 1 capture two, 2 ext clock
  input  wire logic       i_clk_sys,
  input  wire logic [2:0] i_want,
  // pins toward the timer
  output logic            o_capture_pin_one,
  output logic            o_capture_pin_two,
  output logic            o_ext_clock_pin
);
  // registered like a real source; the clock pin only moves when asked,
  // so it stands still between counted edges
  always_ff @(posedge i_clk_sys) begin
    o_capture_pin_one <= i_want[0];
    o_capture_pin_two <= i_want[1];
    o_ext_clock_pin   <= i_want[2];
  end
endmodule : cct_far_side

//--- verification/cct_chk.sv
// checker for the timer top: bus answers, read data and pin ownership
// assumes it is bound into the timer top and sees only its ports
`timescale 1ns/1ns
module cct_chk (
  // clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_rst_n,
  // bus handshakes and read answer
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic        o_bvalid,
  input wire logic [31:0] i_araddr,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0]  o_rresp,
  input wire logic        o_rvalid,
  // timer pins
  input wire logic        o_compare_pin_one,
  input wire logic        o_compare_pin_one_en,
  input wire logic        o_compare_pin_two,
  input wire logic        o_compare_pin_two_en
);
  logic [31:0] ar_addr_r;
  // keep the read address so the answer can be judged against it
  always_ff @(posedge i_clk_sys) begin
    if (i_arvalid && o_arready) ar_addr_r <= i_araddr;
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  a_read_answer: assert property (i_arvalid && o_arready |-> ##[1:2] o_rvalid)
    else $error("read not answered");
  a_write_answer: assert property (i_awvalid && o_awready && i_wvalid && o_wready
    |-> ##[1:3] o_bvalid) else $error("write not answered");
  a_ar_refused: assert property (o_rvalid |-> !o_arready)
    else $error("read taken while answer pending");
  a_upper_zero: assert property (o_rvalid |-> o_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_status_low: assert property (o_rvalid && ar_addr_r == 32'h8 |-> o_rdata[2:0] == 3'h0)
    else $error("unused status bits set");
  a_unmapped_err: assert property (o_rvalid && ar_addr_r > 32'h38 |-> o_rresp == 2'h3)
    else $error("unmapped read not refused");
  a_en_cause: assert property ($changed({o_compare_pin_one_en, o_compare_pin_two_en})
    |-> $past(o_bvalid, 1) || $past(o_bvalid, 2)) else $error("pin enable moved alone");
  a_pin_two_owned: assert property ($changed(o_compare_pin_two) |-> o_compare_pin_two_en)
    else $error("pin two moved while not owned");
  a_pin_one_owned: assert property ($changed(o_compare_pin_one) |-> o_compare_pin_one_en)
    else $error("pin one moved while not owned");
  c_read: cover property (o_rvalid && o_rresp == 2'h0);
  c_write: cover property (o_bvalid);
  c_pin_fall: cover property ($fell(o_compare_pin_one));
endmodule : cct_chk

//--- verification/tb_top.sv
// self-checking bench for the capture/compare timer over axi4-lite
// assumes the timer package, top, checker and far-side model are compiled first
`timescale 1ns/1ns
module tb_top;
  logic        i_clk_sys = 1'b0, i_rst_n = 1'b0;
  logic [31:0] i_awaddr = 32'h0, i_wdata = 32'h0, i_araddr = 32'h0, o_rdata;
  logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
  logic        i_arvalid = 1'b0, i_rready = 1'b0, o_timer_irq;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  logic        i_capture_pin_one, i_capture_pin_two, i_ext_clock_pin;
  logic        o_compare_pin_one, o_compare_pin_one_en, o_compare_pin_two, o_compare_pin_two_en;
  logic [1:0]  o_bresp, o_rresp, rr;
  logic [3:0]  i_wstrb = 4'hF;
  logic [2:0]  want = 3'h0;
  logic [7:0]  v, w, e;
  logic [3:0]  idx_tab [7] = '{4'h2, 4'h0, 4'h1, 4'h5, 4'h6, 4'h7, 4'h8};
  logic [7:0]  rst_tab [7] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00};
  int          div_tab [3] = '{4, 2, 8};
  int          n_fail = 0, check_count = 0, cyc = 0, t0;
  localparam logic [3:0] ST = 4'h2;
  localparam logic [3:0] CL = 4'hA;
  capture_compare_timer_regs i_dut (.i_clk_sys, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready,
    .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr,
    .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_capture_pin_one,
    .i_capture_pin_two, .i_ext_clock_pin, .o_compare_pin_one, .o_compare_pin_one_en,
    .o_compare_pin_two, .o_compare_pin_two_en, .o_timer_irq);
  cct_far_side i_far (.i_clk_sys, .i_want(want), .o_capture_pin_one(i_capture_pin_one),
    .o_capture_pin_two(i_capture_pin_two), .o_ext_clock_pin(i_ext_clock_pin));
  // 250 MHz clock; the cycle count doubles as the hang limit
  always #2 i_clk_sys = ~i_clk_sys;
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    bit ka, kw;
    ka = 1'b0;
    kw = 1'b0;
    @(posedge i_clk_sys);
    i_awaddr <= {26'h0, idx, 2'h0};
    i_wdata <= {24'h0, d};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    while (!(ka && kw)) begin
      @(posedge i_clk_sys);
      ka = ka | o_awready;
      kw = kw | o_wready;
      if (ka) i_awvalid <= 1'b0;
      if (kw) i_wvalid <= 1'b0;
    end
    do @(posedge i_clk_sys); while (!o_bvalid);
    rr = o_bresp;
    i_bready <= 1'b0;
  endtask : wr
  // read: hold the request until taken, data is taken with rvalid
  task automatic rd(input logic [3:0] idx, output logic [7:0] d);
    @(posedge i_clk_sys);
    i_araddr <= {26'h0, idx, 2'h0};
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do @(posedge i_clk_sys); while (!o_arready);
    i_arvalid <= 1'b0;
    do @(posedge i_clk_sys); while (!o_rvalid);
    i_rready <= 1'b0;
    d = o_rdata[7:0];
    rr = o_rresp;
  endtask : rd
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // read a register and compare the masked bits
  task automatic rc(input logic [3:0] idx, input logic [7:0] m, input logic [7:0] x);
    logic [7:0] d;
    rd(idx, d);
    chk(d & m, x);
  endtask : rc
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : tick
  task automatic done(input int n);
    $display("test %0d done", n);
  endtask : done
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  initial begin
    tick(16);
    i_rst_n <= 1'b1;
    // status first: the counter wraps soon after reset
    for (int k = 0; k < 7; k++) rc(idx_tab[k], 8'hFF, rst_tab[k]);
    rd(4'hF, v);
    chk({6'h0, rr}, 8'h03);
    wr(4'hF, 8'h00);
    chk({6'h0, rr}, 8'h03);
    done(1);
    // forced levels only reach pins the timer owns
    wr(4'h1, 8'hC0);
    wr(4'h0, 8'h09);
    tick(3);
    chk({5'h0, o_compare_pin_one_en, o_compare_pin_two_en, o_compare_pin_one}, 8'h07);
    wr(4'h0, 8'h14);
    tick(3);
    chk({7'h0, o_compare_pin_two}, 8'h01);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h10);
    tick(3);
    chk({7'h0, o_compare_pin_two}, 8'h01);
    done(2);
    // counting rate per divider, then the external pin on rising edges
    for (int s = 0; s < 3; s++) begin
      wr(4'h1, {4'h0, s[1:0], 2'h0});
      rd(CL, v);
      t0 = cyc;
      tick(60);
      rd(CL, w);
      e = w - v - 8'((cyc - t0) / div_tab[s]);
      chk({7'h0, e == 8'h00 || e == 8'h01 || e == 8'hFF}, 8'h01);
    end
    wr(4'h1, 8'h0D);
    rd(CL, v);
    want[2] <= 1'b1;
    tick(4);
    rd(CL, w);
    chk(w - v, 8'h01);
    want[2] <= 1'b0;
    tick(4);
    rd(CL, v);
    chk(v - w, 8'h00);
    done(3);
    // overflow: only the counter low byte clears it, alternate does not
    wr(4'h1, 8'h08);
    rd(ST, v);
    wr(CL, 8'h00);
    rc(ST, 8'h27, 8'h00);
    tick(40);
    rc(ST, 8'h20, 8'h20);
    rd(4'hC, v);
    rc(ST, 8'h20, 8'h20);
    wr(4'h0, 8'h20);
    tick(3);
    chk({7'h0, o_timer_irq}, 8'h01);
    rd(CL, v);
    tick(3);
    chk({7'h0, o_timer_irq}, 8'h00);
    rc(ST, 8'h20, 8'h00);
    done(4);
    // captures: wrong edge ignored, right edge flags, copies and interrupts
    wr(4'h0, 8'h00);
    want[0] <= 1'b1;
    tick(4);
    rc(ST, 8'h80, 8'h00);
    wr(4'h0, 8'h82);
    want[0] <= 1'b0;
    tick(4);
    rc(ST, 8'h80, 8'h00);
    want[0] <= 1'b1;
    tick(4);
    rc(ST, 8'h80, 8'h80);
    chk({7'h0, o_timer_irq}, 8'h01);
    rd(4'h4, v);
    chk({7'h0, ^v === 1'bx}, 8'h00);
    rc(ST, 8'h80, 8'h00);
    wr(4'h1, 8'h0A);
    want[1] <= 1'b1;
    tick(4);
    rc(ST, 8'h10, 8'h10);
    rd(4'hE, v);
    rc(ST, 8'h10, 8'h00);
    done(5);
    // compare one at 0040 from FFFC: 68 ticks at divide by two
    wr(4'h1, 8'h84);
    wr(4'h0, 8'h40);
    wr(4'h5, 8'h00);
    wr(4'h6, 8'h40);
    wr(CL, 8'h00);
    tick(100);
    rc(ST, 8'h40, 8'h00);
    chk({7'h0, o_compare_pin_one}, 8'h01);
    tick(60);
    rc(ST, 8'h40, 8'h40);
    chk({6'h0, o_compare_pin_one, o_timer_irq}, 8'h01);
    rd(4'h6, v);
    rc(ST, 8'h40, 8'h00);
    done(6);
    // pulse width beats one pulse: compare two at 0050 ends each period
    wr(CL, 8'h00);
    wr(4'h7, 8'h00);
    wr(4'h8, 8'h50);
    wr(4'h1, 8'hB4);
    tick(200);
    rc(ST, 8'hC8, 8'h80);
    rd(CL, v);
    chk({7'h0, v <= 8'h50 || v >= 8'hFC}, 8'h01);
    done(7);
    summarize();
  end
endmodule : tb_top
bind capture_compare_timer_regs cct_chk i_chk (.i_clk_sys, .i_rst_n, .i_awvalid, .o_awready,
  .i_wvalid, .o_wready, .o_bvalid, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp,
  .o_rvalid, .o_compare_pin_one, .o_compare_pin_one_en, .o_compare_pin_two,
  .o_compare_pin_two_en);
